// >>> design/ssibe_cfg.svh
`ifndef SSIBE_CFG_SVH
`define SSIBE_CFG_SVH

// System clock
`define SSIBE_CLK_NS          5

// SPI serial clock made by division of clk
`define SSIBE_SPI_PERIOD_NS   125
`define SSIBE_SPI_HALF_CYC    ((`SSIBE_SPI_PERIOD_NS / 2) / `SSIBE_CLK_NS)

// Two-wire clock at 400 kHz, low and high halves are least times
`define SSIBE_I2C_PERIOD_NS   2500
`define SSIBE_I2C_HALF_CYC    (((`SSIBE_I2C_PERIOD_NS / 2) + `SSIBE_CLK_NS - 1) / `SSIBE_CLK_NS)

// Operating mode field encodings
`define SSIBE_MODE_SPI        2'b11
`define SSIBE_MODE_I2C        2'b10

// Framing
`define SSIBE_BYTE_BITS       8
`define SSIBE_ACK_BIT         4'h8
`define SSIBE_SPI_LAST_EDGE   5'h0f

// Command FIFO
`define SSIBE_FIFO_WIDTH      10
`define SSIBE_FIFO_DEPTH      16

`endif

// >>> design/ssibe_pkg.sv
package ssibe_pkg;

   typedef enum logic [1:0] {
      CMD_WRITE = 2'b00,
      CMD_START = 2'b01,
      CMD_READ  = 2'b10,
      CMD_STOP  = 2'b11
   } ssibe_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_SPI_SEL   = 4'b0001,
      ST_SPI_XFER  = 4'b0010,
      ST_SPI_END   = 4'b0011,
      ST_I2C_START = 4'b0100,
      ST_I2C_LOW   = 4'b0101,
      ST_I2C_HIGH  = 4'b0110,
      ST_I2C_HOLD  = 4'b0111,
      ST_I2C_STOP  = 4'b1000
   } ssibe_state_t;

   typedef struct packed {
      ssibe_state_t st;
      logic [8:0]   cnt;
      logic [4:0]   edg;
      logic [3:0]   bitn;
      logic [1:0]   step;
      logic [7:0]   sh;
      logic [7:0]   rx;
      logic         rd;
      logic         ack_en;
      logic         pol;
      logic         pha;
      logic         sck;
      logic         ss_n;
      logic         mosi;
      logic         scl_oe;
      logic         sda_oe;
      logic         busy;
      logic         seen_high;
      logic         rx_valid;
      logic         rx_ack;
      logic         arb_lost;
      logic         m1;
      logic         m2;
      logic         c1;
      logic         c2;
      logic         c3;
      logic         d1;
      logic         d2;
      logic         d3;
   } ssibe_host_st_t;

endpackage

// >>> design/ssibe_fifo.sv
`timescale 1ns/1ps
module ssibe_fifo #(
   parameter int W = 10,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Fill side
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);

   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                rdy;
   } ssibe_fifo_st_t;

   ssibe_fifo_st_t q;
   ssibe_fifo_st_t n;
   logic           push;
   logic           pop;

   assign in_ready  = q.rdy;
   assign out_valid = (q.cnt != '0);
   assign out_data  = q.mem[q.rp];

   always_comb
   begin
      n    = q;
      push = in_valid && q.rdy;
      pop  = out_valid && out_ready;
      if (push)
      begin
         n.mem[q.wp] = in_data;
         n.wp        = q.wp + AW'(1);
      end
      if (pop)
      begin
         n.rp = q.rp + AW'(1);
      end
      n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      n.rdy = (n.cnt < (AW+1)'(D));
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q     <= '0;
         q.rdy <= 1'b1;
      end
      else
      begin
         q <= n;
      end
   end

endmodule

// >>> design/ssibe_host.sv
// Function
// - Four SPI formats from polarity and phase; sample one edge, set up other
// - Phase 0: both sample on first edge, shift next bit on second
// - Phase 0: master returns slave select high between transfers
// - Phase 1: first edge shifts bit out, second samples, third shifts next
// - Data line changes only while clock low, except START and STOP
// - Data falling with clock high is START, rising is STOP
// - Only the master makes START and STOP; repeated START equals START
// - Bytes are eight bits MSB first plus acknowledge, count unlimited
// - Slave may hold clock low; master waits until it is released
// - Master clocks acknowledge; transmitter releases data; receiver pulls low
// - Master receiver withholds acknowledge after last byte, then STOP or START
`timescale 1ns/1ps
`include "ssibe_cfg.svh"
module ssibe_host (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Command stream
   input  wire logic                cmd_valid,
   output      logic                cmd_ready,
   input  wire ssibe_pkg::ssibe_cmd_t cmd_code,
   input  wire logic [7:0]          cmd_data,
   // Configuration
   input  wire logic [1:0]          unit_operating_mode_field,
   input  wire logic                clock_polarity_bit,
   input  wire logic                clock_phase_bit,
   // Results
   output      logic                rx_valid,
   output      logic [7:0]          rx_data,
   output      logic                rx_ack,
   output      logic                arb_lost,
   output      logic                bus_busy,
   // SPI pins
   output      logic                serial_clock_pin,
   output      logic                slave_select_pin_n,
   output      logic                mosi_pin,
   input  wire logic                miso_pin,
   // Two-wire pins
   input  wire logic                two_wire_clock_line_in,
   output      logic                two_wire_clock_line_out,
   output      logic                two_wire_clock_line_oe,
   input  wire logic                two_wire_data_line_in,
   output      logic                two_wire_data_line_out,
   output      logic                two_wire_data_line_oe
);
   import ssibe_pkg::*;

   localparam logic [8:0] SPI_HALF = 9'(`SSIBE_SPI_HALF_CYC);
   localparam logic [8:0] I2C_HALF = 9'(`SSIBE_I2C_HALF_CYC);
   localparam logic [8:0] I2C_SETUP = 9'(`SSIBE_I2C_HALF_CYC / 2);

   ssibe_host_st_t q;
   ssibe_host_st_t n;
   logic           f_valid;
   logic           f_take;
   logic [9:0]     f_data;
   ssibe_cmd_t     f_cmd;
   logic           is_spi;

   function automatic logic timer_done(input logic [8:0] c, input logic [8:0] lim);
      return (c >= lim);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Command FIFO
   ssibe_fifo #(
      .W (`SSIBE_FIFO_WIDTH),
      .D (`SSIBE_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .in_data   ({cmd_code, cmd_data}),
      .out_valid (f_valid),
      .out_ready (f_take),
      .out_data  (f_data)
   );

   assign f_cmd  = ssibe_cmd_t'(f_data[9:8]);
   assign is_spi = (unit_operating_mode_field == `SSIBE_MODE_SPI);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      n          = q;
      f_take     = 1'b0;
      n.m1       = miso_pin;
      n.m2       = q.m1;
      n.c1       = two_wire_clock_line_in;
      n.c2       = q.c1;
      n.c3       = q.c2;
      n.d1       = two_wire_data_line_in;
      n.d2       = q.d1;
      n.d3       = q.d2;
      n.rx_valid = 1'b0;
      n.arb_lost = 1'b0;
      n.cnt      = q.cnt + 9'h001;
      // Bus monitor
      if (q.c2 && q.c3 && q.d3 && !q.d2)
      begin
         n.busy = 1'b1;
      end
      else if (q.c2 && q.c3 && !q.d3 && q.d2)
      begin
         n.busy = 1'b0;
      end
      case (q.st)
         ST_IDLE:
         begin
            n.cnt = 9'h000;
            if (is_spi && q.ss_n)
            begin
               n.sck = clock_polarity_bit;
            end
            if (f_valid)
            begin
               if (is_spi)
               begin
                  f_take = 1'b1;
                  if (f_cmd == CMD_STOP)
                  begin
                     n.ss_n = 1'b1;
                  end
                  else
                  begin
                     n.pol = clock_polarity_bit;
                     n.pha = clock_phase_bit;
                     n.sck = clock_polarity_bit;
                     n.edg = 5'h00;
                     n.rx  = 8'h00;
                     if (!clock_phase_bit)
                     begin
                        n.mosi = f_data[7];
                        n.sh   = {f_data[6:0], 1'b0};
                     end
                     else
                     begin
                        n.sh = f_data[7:0];
                     end
                     n.st = q.ss_n ? ST_SPI_SEL : ST_SPI_XFER;
                  end
               end
               else if (f_cmd == CMD_START)
               begin
                  if (!q.busy)
                  begin
                     f_take = 1'b1;
                     n.sh   = f_data[7:0];
                     n.rd   = 1'b0;
                     n.step = 2'h0;
                     n.st   = ST_I2C_START;
                  end
               end
               else
               begin
                  f_take = 1'b1;
               end
            end
         end
         ST_SPI_SEL:
         begin
            n.ss_n = 1'b0;
            if (timer_done(q.cnt, SPI_HALF))
            begin
               n.cnt = 9'h000;
               n.st  = ST_SPI_XFER;
            end
         end
         ST_SPI_XFER:
         begin
            if (timer_done(q.cnt, SPI_HALF))
            begin
               n.cnt = 9'h000;
               n.sck = ~q.sck;
               n.edg = q.edg + 5'h01;
               if (q.edg[0] == q.pha)
               begin
                  n.rx = {q.rx[6:0], q.m2};
               end
               else
               begin
                  n.mosi = q.sh[7];
                  n.sh   = {q.sh[6:0], 1'b0};
               end
               if (q.edg == `SSIBE_SPI_LAST_EDGE)
               begin
                  n.st = ST_SPI_END;
               end
            end
         end
         ST_SPI_END:
         begin
            if (timer_done(q.cnt, SPI_HALF))
            begin
               n.rx_valid = 1'b1;
               n.st       = ST_IDLE;
               if (!q.pha)
               begin
                  n.ss_n = 1'b1;
               end
            end
         end
         ST_I2C_START:
         begin
            case (q.step)
               2'h0:
               begin
                  n.sda_oe = 1'b0;
                  if (timer_done(q.cnt, I2C_HALF))
                  begin
                     n.cnt    = 9'h000;
                     n.scl_oe = 1'b0;
                     n.step   = 2'h1;
                  end
               end
               2'h1:
               begin
                  if (!q.c2)
                  begin
                     n.cnt = 9'h000;
                  end
                  else if (timer_done(q.cnt, I2C_HALF))
                  begin
                     n.cnt    = 9'h000;
                     n.sda_oe = 1'b1;
                     n.step   = 2'h2;
                  end
               end
               default:
               begin
                  if (timer_done(q.cnt, I2C_HALF))
                  begin
                     n.cnt    = 9'h000;
                     n.scl_oe = 1'b1;
                     n.bitn   = 4'h0;
                     n.st     = ST_I2C_LOW;
                  end
               end
            endcase
         end
         ST_I2C_LOW:
         begin
            n.scl_oe = 1'b1;
            if (q.cnt == I2C_SETUP)
            begin
               if (q.bitn < `SSIBE_ACK_BIT)
               begin
                  n.sda_oe = q.rd ? 1'b0 : ~q.sh[7];
               end
               else
               begin
                  n.sda_oe = q.rd ? q.ack_en : 1'b0;
               end
            end
            if (timer_done(q.cnt, I2C_HALF))
            begin
               n.cnt       = 9'h000;
               n.scl_oe    = 1'b0;
               n.seen_high = 1'b0;
               n.st        = ST_I2C_HIGH;
            end
         end
         ST_I2C_HIGH:
         begin
            if (!q.seen_high)
            begin
               n.cnt = 9'h000;
               if (q.c2)
               begin
                  n.seen_high = 1'b1;
                  if (q.bitn < `SSIBE_ACK_BIT)
                  begin
                     n.rx = {q.rx[6:0], q.d2};
                     if (!q.rd && !q.sda_oe && !q.d2)
                     begin
                        n.arb_lost = 1'b1;
                        n.sda_oe   = 1'b0;
                        n.st       = ST_IDLE;
                     end
                  end
                  else
                  begin
                     n.rx_ack = !q.d2;
                  end
               end
            end
            else if (!q.c2 || timer_done(q.cnt, I2C_HALF))
            begin
               n.scl_oe = 1'b1;
               n.cnt    = 9'h000;
               if (q.bitn == `SSIBE_ACK_BIT)
               begin
                  n.rx_valid = 1'b1;
                  n.st       = ST_I2C_HOLD;
               end
               else
               begin
                  n.bitn = q.bitn + 4'h1;
                  n.sh   = {q.sh[6:0], 1'b0};
                  n.st   = ST_I2C_LOW;
               end
            end
         end
         ST_I2C_HOLD:
         begin
            n.cnt = 9'h000;
            if (f_valid)
            begin
               f_take = 1'b1;
               n.bitn = 4'h0;
               n.step = 2'h0;
               case (f_cmd)
                  CMD_WRITE:
                  begin
                     n.sh = f_data[7:0];
                     n.rd = 1'b0;
                     n.st = ST_I2C_LOW;
                  end
                  CMD_READ:
                  begin
                     n.rd     = 1'b1;
                     n.ack_en = f_data[0];
                     n.st     = ST_I2C_LOW;
                  end
                  CMD_START:
                  begin
                     n.sh = f_data[7:0];
                     n.rd = 1'b0;
                     n.st = ST_I2C_START;
                  end
                  default:
                  begin
                     n.st = ST_I2C_STOP;
                  end
               endcase
            end
         end
         ST_I2C_STOP:
         begin
            if (q.step == 2'h0)
            begin
               n.sda_oe = 1'b1;
               if (timer_done(q.cnt, I2C_HALF))
               begin
                  n.cnt    = 9'h000;
                  n.scl_oe = 1'b0;
                  n.step   = 2'h1;
               end
            end
            else if (!q.c2)
            begin
               n.cnt = 9'h000;
            end
            else if (timer_done(q.cnt, I2C_HALF))
            begin
               n.sda_oe = 1'b0;
               n.st     = ST_IDLE;
            end
         end
         default:
         begin
            n.st     = ST_IDLE;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
         end
      endcase
      if (n.arb_lost)
      begin
         n.scl_oe = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q      <= '0;
         q.ss_n <= 1'b1;
      end
      else
      begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign rx_valid                = q.rx_valid;
   assign rx_data                 = q.rx;
   assign rx_ack                  = q.rx_ack;
   assign arb_lost                = q.arb_lost;
   assign bus_busy                = q.busy;
   assign serial_clock_pin        = q.sck;
   assign slave_select_pin_n      = q.ss_n;
   assign mosi_pin                = q.mosi;
   assign two_wire_clock_line_out = 1'b0;
   assign two_wire_clock_line_oe  = q.scl_oe;
   assign two_wire_data_line_out  = 1'b0;
   assign two_wire_data_line_oe   = q.sda_oe;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_held_low;
      q.st == ST_I2C_HIGH && !q.seen_high && !q.c2;
   endsequence

   sequence s_start_edge;
      q.st == ST_I2C_START && q.step == 2'h2;
   endsequence

   a_spi_edge_time: assert property (($changed(q.sck) && $past(q.st) == ST_SPI_XFER) |->
      $past(q.cnt) == SPI_HALF) else $error("serial clock edge off its half period");
   a_spi_idle_pol: assert property ((q.st == ST_IDLE && is_spi && q.ss_n) |=>
      q.sck == $past(clock_polarity_bit)) else $error("idle clock level wrong");
   a_phase0_desel: assert property ((q.rx_valid && is_spi && !q.pha) |-> q.ss_n)
      else $error("select not released after phase 0 byte");
   a_phase1_keep: assert property ((q.rx_valid && is_spi && q.pha) |-> !q.ss_n)
      else $error("select released after phase 1 byte");
   a_sda_stable: assert property ((q.st == ST_I2C_HIGH && $past(q.st) == ST_I2C_HIGH) |->
      $stable(q.sda_oe)) else $error("data changed while clock high");
   a_start_cond: assert property (s_start_edge |-> q.sda_oe && !q.scl_oe)
      else $error("start not data low under released clock");
   a_start_free: assert property (($past(q.st) == ST_IDLE && q.st == ST_I2C_START) |->
      !$past(q.busy)) else $error("start on a busy bus");
   a_arb_release: assert property (q.arb_lost |-> !q.sda_oe && !q.scl_oe && q.st == ST_IDLE)
      else $error("lines still driven after lost arbitration");
   a_stretch_wait: assert property (s_held_low |=> q.st == ST_I2C_HIGH && !q.scl_oe)
      else $error("clock stretch not honoured");
   a_ack_release: assert property ((q.st == ST_I2C_HIGH && q.bitn == 4'h8 && !q.rd) |->
      !q.sda_oe) else $error("transmitter holds data in acknowledge");
   a_busy_start: assert property ((q.c2 && q.c3 && q.d3 && !q.d2) |=> q.busy)
      else $error("busy not set after start");

endmodule

// >>> test/ssibe_dev.sv
`timescale 1ns/1ps
module ssibe_dev (
   // SPI side
   input  wire logic       sck,
   input  wire logic       ss_n,
   input  wire logic       mosi,
   input  wire logic       pol,
   input  wire logic       pha,
   input  wire logic [7:0] tx_byte,
   output      logic       miso,
   output      logic [7:0] rx_byte,
   // Two-wire side
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [7:0] rd_byte,
   output      logic       scl_pull,
   output      logic       sda_pull,
   output      logic [7:0] got_byte
);
   int         n, k, b = 9;
   logic [7:0] sh;
   logic       adr, rw, rd;
   realtime    ts;
   initial
   begin
      miso = 0;
      scl_pull = 0;
      sda_pull = 0;
   end
   ////////////////////////////////////////
   always @(negedge ss_n)
   begin
      ts = $realtime;
      n = pha ? 7 : 6;
      k = 0;
      miso = pha ? ~miso : tx_byte[7];
   end
   always @(posedge ss_n)
      miso = ~miso;
   always @(sck)
   if (!ss_n && $realtime > ts)
   begin
      if ((sck != pol) ^ pha)
      begin
         sh = {sh[6:0], mosi};
         k = k + 1;
      end
      else
      begin
         miso = tx_byte[n];
         n = n - 1;
      end
      if (k == 8)
      begin
         rx_byte = sh;
         k = 0;
         n = 7;
      end
   end
   ////////////////////////////////////////
   always @(negedge sda)
   if (scl)
   begin
      b = -1;
      adr = 1;
      rd = 0;
   end
   always @(posedge sda)
   if (scl)
      b = 9;
   always @(posedge scl)
   if (b == 8 && rd && sda)
      b = 9;
   else if (b >= 0 && b < 8)
   begin
      sh = {sh[6:0], sda};
      rw = sda;
      got_byte = sh;
   end
   always @(negedge scl)
   if (b < 9)
   begin
      if (b == 8)
      begin
         rd = adr ? rw : rd;
         adr = 0;
         b = 0;
      end
      else
         b = b + 1;
      sda_pull = rd ? b < 8 && !rd_byte[7 - b] : b == 8;
      if (b == 0 && !adr)
      begin
         scl_pull = 1;
         #2000 scl_pull = 0;
      end
   end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
   import ssibe_pkg::*;
   logic       clk = 0, rst = 1, cmd_valid = 0, pol = 0, pha = 0, jam = 0;
   ssibe_cmd_t cmd_code = CMD_WRITE;
   logic [7:0] cmd_data = 8'h00, tx_byte = 8'h00, rd_byte = 8'h00, d, q[$];
   logic [1:0] mode = 2'b11;
   logic       cmd_ready, rx_valid, rx_ack, arb_lost, bus_busy, sck, ss_n, mosi, miso;
   logic [7:0] rx_data, rx_byte, got_byte;
   logic       scl_oe, sda_oe, scl_pull, sda_pull;
   wire        scl = !(scl_oe || scl_pull);
   wire        sda = !(sda_oe || sda_pull || jam);
   int         num_errors = 0, n_compared = 0, i;
   always #2.5 clk = ~clk;
   ////////////////////////////////////////
   ssibe_host dut (
      .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_code(cmd_code), .cmd_data(cmd_data), .unit_operating_mode_field(mode),
      .clock_polarity_bit(pol), .clock_phase_bit(pha), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ack(rx_ack), .arb_lost(arb_lost), .bus_busy(bus_busy),
      .serial_clock_pin(sck), .slave_select_pin_n(ss_n), .mosi_pin(mosi),
      .miso_pin(miso), .two_wire_clock_line_in(scl), .two_wire_clock_line_out(),
      .two_wire_clock_line_oe(scl_oe), .two_wire_data_line_in(sda),
      .two_wire_data_line_out(), .two_wire_data_line_oe(sda_oe)
   );
   ssibe_dev dev (
      .sck(sck), .ss_n(ss_n), .mosi(mosi), .pol(pol), .pha(pha), .tx_byte(tx_byte),
      .miso(miso), .rx_byte(rx_byte), .scl(scl), .sda(sda), .rd_byte(rd_byte),
      .scl_pull(scl_pull), .sda_pull(sda_pull), .got_byte(got_byte)
   );
   ////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic send(input ssibe_cmd_t c, input logic [7:0] v);
      @(negedge clk);
      cmd_valid = 1;
      cmd_code = c;
      cmd_data = v;
      @(posedge clk);
      while (cmd_ready !== 1'b1)
         @(posedge clk);
      @(negedge clk);
      cmd_valid = 0;
   endtask
   // Events: 0 byte done, 1 arbitration lost, 2 bus free, 3 clock low, 4 clock high
   function automatic logic ev(input int w);
      case (w)
         0: return rx_valid;
         1: return arb_lost;
         2: return !bus_busy;
         3: return !scl;
         default: return scl;
      endcase
   endfunction
   task automatic wait_ev(input int w, input int lim);
      int k;
      for (k = 0; k < lim; k++)
      begin
         @(negedge clk);
         if (ev(w) === 1'b1)
            return;
      end
      num_errors++;
      $display("Error event %0d expected 1 seen 0", w);
   endtask
   ////////////////////////////////////////
   initial
   begin
      void'($urandom(44));
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 0;
      for (i = 0; i < 4; i++)
      begin
         {pol, pha} = i[1:0];
         tx_byte = 8'($urandom);
         d = 8'($urandom);
         send(CMD_WRITE, d);
         wait_ev(0, 600);
         check("spi rx_data", rx_data, tx_byte);
         check("spi mosi byte", rx_byte, d);
         check("sck idle", sck, pol);
         check("select", ss_n, !pha);
         send(CMD_STOP, 8'h00);
         repeat (40) @(negedge clk);
         check("select idle", ss_n, 1);
      end
      mode = 2'b00;
      send(CMD_WRITE, 8'h5a);
      d = 0;
      repeat (400) @(negedge clk) d += (rx_valid !== 1'b0 || ss_n !== 1'b1);
      check("mode off", d, 0);
      mode = 2'b11;
      {pol, pha} = 2'b01;
      forever
      begin
         @(negedge clk);
         if (cmd_ready !== 1'b1)
            break;
         cmd_valid = 1;
         cmd_code = CMD_WRITE;
         cmd_data = 8'($urandom);
         q.push_back(cmd_data);
         @(posedge clk);
      end
      cmd_valid = 0;
      check("fifo fill", q.size() >= 16 && q.size() <= 18, 1);
      while (q.size() > 0)
      begin
         wait_ev(0, 600);
         check("burst byte", rx_byte, q.pop_front());
         check("select held", ss_n, 0);
      end
      check("fifo empty", cmd_ready, 1);
      send(CMD_STOP, 8'h00);
      repeat (8) @(negedge clk);
      check("burst select idle", ss_n, 1);
      mode = 2'b10;
      rd_byte = 8'($urandom);
      d = {7'($urandom), 1'b0};
      repeat (8) @(negedge clk);
      send(CMD_START, d);
      wait_ev(0, 9000);
      check("addr echo", rx_data, d);
      check("addr ack", rx_ack, 1);
      check("busy", bus_busy, 1);
      d = 8'($urandom);
      send(CMD_WRITE, d);
      wait_ev(0, 9000);
      check("slave got", got_byte, d);
      check("data ack", rx_ack, 1);
      send(CMD_START, {7'($urandom), 1'b1});
      wait_ev(0, 9000);
      check("busy kept", bus_busy, 1);
      send(CMD_READ, 8'h00);
      wait_ev(0, 9000);
      check("read byte", rx_data, rd_byte);
      check("no ack", rx_ack, 0);
      send(CMD_STOP, 8'h00);
      wait_ev(2, 3000);
      check("free", bus_busy, 0);
      send(CMD_START, 8'hff);
      wait_ev(3, 3000);
      jam = 1;
      wait_ev(1, 6000);
      check("released", {scl_oe, sda_oe}, 0);
      wait_ev(4, 500);
      jam = 0;
      wait_ev(2, 100);
      check("free after", bus_busy, 0);
      wrap_up();
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      num_errors++;
      wrap_up();
   end
endmodule
